/* File: rtl/vj_map.svh */
// Address map, field positions, reset values and timing figures of the angle jump detector
`ifndef VJ_MAP_SVH
`define VJ_MAP_SVH
`define VJ_CLK_KHZ      100000
`define VJ_PASS_MS      5
`define VJ_SPAN_MS      20
`define VJ_TRIP_MS      20
`define VJ_ANG_W        16
`define VJ_MAG_W        16
`define VJ_FULL_TURN    17'h08ca0
`define VJ_HALF_TURN    17'h04650
`define VJ_RATIO_SCALE  7'h64
`define VJ_THR_MIN      16'h0005
`define VJ_THR_MAX      16'h0bb8
`define VJ_THR_RST      16'h01f4
`define VJ_LIM_MIN      16'h0001
`define VJ_LIM_MAX      16'h2710
`define VJ_LIM_RST      16'h251c
`define VJ_SEL_MAX      4'ha
`define VJ_SEL_RST      4'h1
`define VJ_A_CTRL       8'h00
`define VJ_A_STAT       8'h04
`define VJ_A_DIFF0      8'h08
`define VJ_A_RATIO0     8'h14
`define VJ_A_PREF       8'h20
`define VJ_A_GRP_LO     8'h40
`define VJ_A_GRP_HI     8'hbf
`define VJ_F_TRIP       2'h0
`define VJ_F_ALARM      2'h1
`define VJ_F_LIMIT      2'h2
`define VJ_CTRL_STAGE   0
`define VJ_CTRL_SEL     4
`define VJ_CTRL_FORCE   8
`define VJ_ST_COND      0
`define VJ_ST_INVALID   2
`define VJ_ST_TRIP      3
`define VJ_ST_ALARM     4
`define VJ_ST_BLOCKED   5
`define VJ_ST_START     6
`endif

/* File: rtl/vj_pkg.sv */
// Types shared by the angle jump detector modules
package vj_pkg;
	typedef enum logic [1:0] {VJ_NORMAL, VJ_BLOCKED, VJ_TRIP, VJ_ALARM} vj_status_e;
	typedef enum logic [3:0] {VJ_PP_ALL, VJ_PP_ANY, VJ_L12, VJ_L23, VJ_L31, VJ_PE_ALL,
		VJ_PE_ANY, VJ_L1, VJ_L2, VJ_L3, VJ_AUX} vj_sel_e;
	typedef logic [2:0] vj_chan_t;
endpackage : vj_pkg

/* File: rtl/vj_div.sv */
// Restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module vj_div #(
	parameter int NUM_W = 23,
	parameter int DEN_W = 16
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Request
	input  wire logic             start,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	// Answer
	output logic                  done,
	output logic [NUM_W-1:0]      quo
);
	logic [DEN_W:0]         rem;
	logic [5:0]             cnt;
	logic [DEN_W+1:0]       trial;
	logic [DEN_W:0]         shifted;

	if (NUM_W < 2 || NUM_W > 63)
		$error("vj_div: NUM_W out of range");

	assign shifted = {rem[DEN_W-1:0], quo[NUM_W-1]};
	assign trial   = {1'b0, shifted} - {2'b00, den};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem  <= '0;
			quo  <= '0;
			cnt  <= '0;
			done <= 1'b0;
		end else if (start) begin
			rem  <= '0;
			quo  <= num;
			cnt  <= 6'(NUM_W);
			done <= 1'b0;
		end else if (cnt != 6'h00) begin
			rem  <= trial[DEN_W+1] ? shifted : trial[DEN_W:0];
			quo  <= {quo[NUM_W-2:0], ~trial[DEN_W+1]};
			cnt  <= cnt - 6'h01;
			done <= (cnt == 6'h01);
		end else begin
			done <= 1'b0;
		end
	end
endmodule : vj_div

/* File: rtl/vj_chan.sv */
// One monitored voltage: angle history, 20 ms angle change, level history
`timescale 1ns/100ps
`include "vj_map.svh"
module vj_chan #(
	parameter int SPAN = 4
) (
	// Clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// Processing pass strobe and measurement
	input  wire logic                           pass,
	input  wire logic [`VJ_ANG_W-1:0]           ang,
	input  wire logic [`VJ_MAG_W-1:0]           mag,
	// Active settings
	input  wire logic [15:0]                    trip_thr,
	input  wire logic [15:0]                    alarm_thr,
	input  wire logic [15:0]                    limit,
	// Results
	output logic signed [`VJ_ANG_W:0]           diff,
	output logic [`VJ_MAG_W-1:0]                mag_now,
	output logic                                trip_hit,
	output logic                                alarm_hit,
	output logic                                under,
	output logic [`VJ_MAG_W+$clog2(SPAN)-1:0]   old_sum
);
	localparam int SUM_W = `VJ_MAG_W + $clog2(SPAN);
	logic [`VJ_ANG_W-1:0] ang_hist [SPAN];
	logic [`VJ_MAG_W-1:0] mag_hist [2*SPAN];
	logic [$clog2(SPAN):0] fill;
	logic                  hist_ok;
	logic [`VJ_ANG_W:0]    abs_diff;
	logic [`VJ_ANG_W:0]    jump;

	// Until a real sample sits a full span back, the difference is against the reset value
	assign hist_ok = (fill == ($clog2(SPAN)+1)'(SPAN + 1));
	assign mag_now = mag_hist[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ang_hist[0] <= '0;
			mag_hist[0] <= '0;
			fill        <= '0;
			diff        <= '0;
		end else if (pass) begin
			ang_hist[0] <= ang;
			mag_hist[0] <= mag;
			if (!hist_ok)
				fill <= fill + 1'b1;
			// Present angle against the one a full span earlier
			diff <= $signed({1'b0, ang}) - $signed({1'b0, ang_hist[SPAN-1]});
		end
	end

	for (genvar i = 1; i < 2*SPAN; i++) begin : g_mag
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				mag_hist[i] <= '0;
			else if (pass)
				mag_hist[i] <= mag_hist[i-1];
		end
	end

	for (genvar i = 1; i < SPAN; i++) begin : g_ang
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				ang_hist[i] <= '0;
			else if (pass)
				ang_hist[i] <= ang_hist[i-1];
		end
	end

	// Older half of the level history: the window ending one span back
	always_comb begin
		old_sum = '0;
		for (int i = SPAN; i < 2*SPAN; i++)
			old_sum = old_sum + SUM_W'(mag_hist[i]);
	end

	// Lead and lag alike; a jump across the zero crossing is taken the short way
	assign abs_diff  = diff[`VJ_ANG_W] ? (`VJ_ANG_W+1)'(-diff) : diff;
	assign jump      = (abs_diff > `VJ_HALF_TURN) ? `VJ_FULL_TURN - abs_diff : abs_diff;
	assign trip_hit  = hist_ok && (jump >= {1'b0, trip_thr});
	assign alarm_hit = hist_ok && (jump >= {1'b0, alarm_thr});
	assign under     = (mag_hist[0] < limit);
endmodule : vj_chan

/* File: rtl/vj_top.sv */
// Voltage angle jump detector: settings over APB, pick-up, blocking, trip pulse
`timescale 1ns/100ps
`include "vj_map.svh"
module vj_top #(
	parameter int PASS_CYCLES = `VJ_PASS_MS * `VJ_CLK_KHZ,
	parameter int TRIP_CYCLES = `VJ_TRIP_MS * `VJ_CLK_KHZ
) (
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic [7:0]                paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Pre-processed measurements, seven channels packed low channel first
	input  wire logic [7*`VJ_ANG_W-1:0]    chan_ang,
	input  wire logic [7*`VJ_MAG_W-1:0]    chan_mag,
	input  wire logic [6:0]                chan_avail,
	// Device controls
	input  wire logic                      block_in,
	input  wire logic                      stage_forcing_en,
	input  wire logic [2:0]                active_group,
	// Function outputs
	output logic                           start_out,
	output logic                           trip_out,
	output logic                           alarm_out,
	output logic                           blocked_out
);
	import vj_pkg::*;

	localparam int SPAN  = `VJ_SPAN_MS / `VJ_PASS_MS;
	localparam int SUM_W = `VJ_MAG_W + $clog2(SPAN);
	localparam int NUM_W = `VJ_MAG_W + 7;

	if (PASS_CYCLES < 4 * NUM_W || TRIP_CYCLES < 1 || (SPAN & (SPAN - 1)) != 0)
		$error("vj_top: pass period too short for the divider, or bad span");

	// Selector decode: {all_mode, slot mask, slot2, slot1, slot0 channel}
	function automatic logic [12:0] sel_decode(input logic [3:0] sel);
		case (vj_sel_e'(sel))
			VJ_PP_ALL: sel_decode = {1'b1, 3'b111, 3'd2, 3'd1, 3'd0};
			VJ_PP_ANY: sel_decode = {1'b0, 3'b111, 3'd2, 3'd1, 3'd0};
			VJ_L12:    sel_decode = {1'b0, 3'b001, 3'd0, 3'd0, 3'd0};
			VJ_L23:    sel_decode = {1'b0, 3'b001, 3'd1, 3'd1, 3'd1};
			VJ_L31:    sel_decode = {1'b0, 3'b001, 3'd2, 3'd2, 3'd2};
			VJ_PE_ALL: sel_decode = {1'b1, 3'b111, 3'd5, 3'd4, 3'd3};
			VJ_PE_ANY: sel_decode = {1'b0, 3'b111, 3'd5, 3'd4, 3'd3};
			VJ_L1:     sel_decode = {1'b0, 3'b001, 3'd3, 3'd3, 3'd3};
			VJ_L2:     sel_decode = {1'b0, 3'b001, 3'd4, 3'd4, 3'd4};
			VJ_L3:     sel_decode = {1'b0, 3'b001, 3'd5, 3'd5, 3'd5};
			VJ_AUX:    sel_decode = {1'b0, 3'b001, 3'd6, 3'd6, 3'd6};
			default:   sel_decode = '0;
		endcase
	endfunction : sel_decode

	function automatic logic in_range(input logic [31:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v[31:16] == 16'h0000) && (v[15:0] >= lo) && (v[15:0] <= hi);
	endfunction : in_range

	// Static settings
	logic        stage;
	logic [3:0]  sel;
	logic [1:0]  force_code;
	// Per setting group thresholds
	logic [15:0] grp_trip  [8];
	logic [15:0] grp_alarm [8];
	logic [15:0] grp_limit [8];
	// Pass timing
	logic [$clog2(PASS_CYCLES)-1:0] pass_cnt;
	logic                           pass;
	logic                           pass_d;
	// Decision state
	logic [$clog2(TRIP_CYCLES+1)-1:0] trip_cnt;
	logic                             alarm_q;
	logic                             blocked_q;
	logic                             start_q;
	logic                             invalid_q;
	vj_status_e                       cond;
	logic [`VJ_MAG_W-1:0]             pref;
	// Ratio sequencer
	logic [1:0]           div_slot;
	logic                 div_start;
	logic                 div_done;
	logic [NUM_W-1:0]     div_quo;
	logic [15:0]          ratio [3];
	// Results per input channel
	logic signed [`VJ_ANG_W:0] diff [7];
	logic [`VJ_MAG_W-1:0]      mag_now [7];
	logic [SUM_W-1:0]          old_sum [7];
	logic [6:0]                trip_hit;
	logic [6:0]                alarm_hit;
	logic [6:0]                under;

	// Selection and group; a history per channel, so a new selection compares no two channels
	wire [12:0]   dec       = sel_decode(sel);
	wire          all_mode  = dec[12];
	wire [2:0]    mask      = dec[11:9];
	wire [2:0]    s0_ch     = dec[2:0];
	wire [2:0]    s1_ch     = dec[5:3];
	wire [2:0]    s2_ch     = dec[8:6];
	wire [15:0]   trip_thr  = grp_trip[active_group];
	wire [15:0]   alarm_thr = grp_alarm[active_group];
	wire [15:0]   limit     = grp_limit[active_group];
	wire [6:0]    need      = (7'(mask[0]) << dec[2:0]) | (7'(mask[1]) << dec[5:3])
		| (7'(mask[2]) << dec[8:6]);
	wire          sel_ok    = ((need & chan_avail) == need);

	for (genvar c = 0; c < 7; c++) begin : g_chan
		vj_chan #(.SPAN(SPAN)) u_chan (
			.pclk      (pclk),
			.presetn   (presetn),
			.pass      (pass),
			.ang       (chan_ang[c*`VJ_ANG_W +: `VJ_ANG_W]),
			.mag       (chan_mag[c*`VJ_MAG_W +: `VJ_MAG_W]),
			.trip_thr  (trip_thr),
			.alarm_thr (alarm_thr),
			.limit     (limit),
			.diff      (diff[c]),
			.mag_now   (mag_now[c]),
			.trip_hit  (trip_hit[c]),
			.alarm_hit (alarm_hit[c]),
			.under     (under[c]),
			.old_sum   (old_sum[c])
		);
	end

	// Pick-up over the selected slots, evaluated one cycle after each pass
	wire [2:0] t_sel      = {trip_hit[s2_ch], trip_hit[s1_ch], trip_hit[s0_ch]} & mask;
	wire [2:0] a_sel      = {alarm_hit[s2_ch], alarm_hit[s1_ch], alarm_hit[s0_ch]} & mask;
	wire [2:0] u_sel      = {under[s2_ch], under[s1_ch], under[s0_ch]} & mask;
	wire       pick_trip  = sel_ok && (all_mode ? (t_sel == mask) : (t_sel != 3'b000));
	wire       pick_alarm = stage && sel_ok
		&& (all_mode ? (a_sel == mask) : (a_sel != 3'b000));
	wire       pickup     = pick_trip || pick_alarm;
	wire       blocking   = block_in || (u_sel != 3'b000);
	wire       trip_fire  = pass_d && pick_trip && !blocking && (trip_cnt == '0);
	wire       alarm_rise = pass_d && pick_alarm && !blocking && !alarm_q;
	wire       forcing    = stage_forcing_en;

	// Live status before any override
	vj_status_e next_cond;
	assign next_cond = (trip_cnt != '0) ? VJ_TRIP : alarm_q ? VJ_ALARM
		: blocked_q ? VJ_BLOCKED : VJ_NORMAL;
	wire       pass_end   = (pass_cnt == ($clog2(PASS_CYCLES))'(PASS_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pass_cnt <= '0;
			pass     <= 1'b0;
			pass_d   <= 1'b0;
		end else begin
			pass     <= pass_end;
			pass_cnt <= pass_end ? '0 : pass_cnt + 1'b1;
			pass_d   <= pass;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_cnt  <= '0;
			alarm_q   <= 1'b0;
			blocked_q <= 1'b0;
			start_q   <= 1'b0;
			invalid_q <= 1'b0;
			pref      <= '0;
		end else begin
			if (trip_fire)
				trip_cnt <= ($clog2(TRIP_CYCLES+1))'(TRIP_CYCLES);
			else if (trip_cnt != '0)
				trip_cnt <= trip_cnt - 1'b1;
			if (pass_d) begin
				alarm_q   <= pick_alarm && !blocking;
				blocked_q <= pickup && blocking;
				start_q   <= pickup && !blocking;
				invalid_q <= !sel_ok;
			end
			if (trip_fire || alarm_rise)
				pref <= `VJ_MAG_W'(old_sum[s0_ch] >> $clog2(SPAN));
		end
	end

	// Outputs follow the override while forcing is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond        <= VJ_NORMAL;
			trip_out    <= 1'b0;
			alarm_out   <= 1'b0;
			blocked_out <= 1'b0;
			start_out   <= 1'b0;
		end else if (forcing) begin
			cond        <= vj_status_e'(force_code);
			trip_out    <= (vj_status_e'(force_code) == VJ_TRIP);
			alarm_out   <= (vj_status_e'(force_code) == VJ_ALARM);
			blocked_out <= (vj_status_e'(force_code) == VJ_BLOCKED);
			start_out   <= 1'b0;
		end else begin
			cond        <= next_cond;
			trip_out    <= (trip_cnt != '0);
			alarm_out   <= alarm_q;
			blocked_out <= blocked_q;
			start_out   <= start_q;
		end
	end

	// Ratios computed one slot after another on a shared divider
	vj_div #(.NUM_W(NUM_W), .DEN_W(16)) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (div_start),
		.num     (NUM_W'(mag_now[dec[3*div_slot +: 3]] * `VJ_RATIO_SCALE)),
		.den     (limit),
		.done    (div_done),
		.quo     (div_quo)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_slot  <= '0;
			div_start <= 1'b0;
			ratio[0]  <= '0;
			ratio[1]  <= '0;
			ratio[2]  <= '0;
		end else if (pass_d) begin
			div_slot  <= '0;
			div_start <= 1'b1;
		end else if (div_done) begin
			// Saturate rather than wrap when the level is far above the limit
			ratio[div_slot] <= (div_quo[NUM_W-1:16] != '0) ? 16'hffff : div_quo[15:0];
			div_slot        <= div_slot + 2'd1;
			div_start       <= (div_slot != 2'd2);
		end else begin
			div_start <= 1'b0;
		end
	end

	// APB decode; zero wait states, read data captured in the setup phase
	wire        setup    = psel && !penable;
	wire        access   = psel && penable;
	wire        a_ctrl   = (paddr == `VJ_A_CTRL);
	wire        a_stat   = (paddr == `VJ_A_STAT);
	wire        a_diff   = (paddr >= `VJ_A_DIFF0) && (paddr < `VJ_A_RATIO0);
	wire        a_ratio  = (paddr >= `VJ_A_RATIO0) && (paddr < `VJ_A_PREF);
	wire        a_pref   = (paddr == `VJ_A_PREF);
	wire        a_grp    = (paddr >= `VJ_A_GRP_LO) && (paddr <= `VJ_A_GRP_HI)
		&& (paddr[3:2] != 2'h3);
	wire [2:0]  g_idx    = 3'(paddr[7:4] - 4'h4);
	wire [1:0]  f_idx    = paddr[3:2];
	wire [1:0]  r_idx    = 2'(paddr[4:2] - (a_diff ? 3'h2 : 3'h5));
	wire        aligned  = (paddr[1:0] == 2'b00);
	wire        mapped   = aligned && (a_ctrl || a_stat || a_diff || a_ratio || a_pref || a_grp);
	wire        ctrl_ok  = (pwdata[`VJ_CTRL_SEL +: 4] <= `VJ_SEL_MAX);
	wire [15:0] lo       = (f_idx == `VJ_F_LIMIT) ? `VJ_LIM_MIN : `VJ_THR_MIN;
	wire [15:0] hi       = (f_idx == `VJ_F_LIMIT) ? `VJ_LIM_MAX : `VJ_THR_MAX;
	wire        wr_ok    = a_ctrl ? ctrl_ok : a_grp ? in_range(pwdata, lo, hi) : 1'b0;
	wire        wr_fire  = access && pwrite && mapped && wr_ok;
	wire [31:0] st_word  = (32'(cond) << `VJ_ST_COND) | (32'(invalid_q) << `VJ_ST_INVALID)
		| (32'(trip_out) << `VJ_ST_TRIP) | (32'(alarm_out) << `VJ_ST_ALARM)
		| (32'(blocked_out) << `VJ_ST_BLOCKED) | (32'(start_out) << `VJ_ST_START);
	wire [31:0] ctrl_wd  = (32'(stage) << `VJ_CTRL_STAGE) | (32'(sel) << `VJ_CTRL_SEL)
		| (32'(force_code) << `VJ_CTRL_FORCE);
	wire [15:0] grp_rd   = (f_idx == `VJ_F_TRIP) ? grp_trip[g_idx]
		: (f_idx == `VJ_F_ALARM) ? grp_alarm[g_idx] : grp_limit[g_idx];
	wire [31:0] rd_data  = !mapped ? 32'h0000_0000
		: a_ctrl ? ctrl_wd
		: a_stat ? st_word
		: a_diff ? 32'($signed(diff[dec[3*r_idx +: 3]]))
		: a_ratio ? 32'(ratio[r_idx])
		: a_pref ? 32'(pref)
		: 32'(grp_rd);

	assign pready  = 1'b1;
	assign pslverr = access && (!mapped || (pwrite && !wr_ok));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (setup && !pwrite)
			prdata <= rd_data;
	end

	// Static settings have no group index, so a group switch cannot touch them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage      <= 1'b0;
			sel        <= `VJ_SEL_RST;
			force_code <= 2'b00;
		end else if (wr_fire && a_ctrl) begin
			stage      <= pwdata[`VJ_CTRL_STAGE];
			sel        <= pwdata[`VJ_CTRL_SEL +: 4];
			force_code <= pwdata[`VJ_CTRL_FORCE +: 2];
		end
	end

	for (genvar g = 0; g < 8; g++) begin : g_grp
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				grp_trip[g]  <= `VJ_THR_RST;
				grp_alarm[g] <= `VJ_THR_RST;
				grp_limit[g] <= `VJ_LIM_RST;
			end else if (wr_fire && a_grp && g_idx == 3'(g)) begin
				if (f_idx == `VJ_F_TRIP)
					grp_trip[g] <= pwdata[15:0];
				if (f_idx == `VJ_F_ALARM)
					grp_alarm[g] <= pwdata[15:0];
				if (f_idx == `VJ_F_LIMIT)
					grp_limit[g] <= pwdata[15:0];
			end
		end
	end
endmodule : vj_top

/* File: verif/vj_top_sva.sv */
// Port checker of the angle jump detector
`timescale 1ns/100ps
module vj_top_chk #(
	parameter int PASS_CYCLES = 200,
	parameter int TRIP_CYCLES = 50
) (
	// Clock, reset and APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Controls and outputs
	input wire logic        stage_forcing_en,
	input wire logic        start_out,
	input wire logic        trip_out,
	input wire logic        alarm_out,
	input wire logic        blocked_out
);
	int         tlen;
	logic       taint;
	logic       stg;
	logic [1:0] fcode;
	logic [1:0] fage;
	wire        acc = psel && penable;
	wire        cwr = acc && pwrite && paddr == 8'h00 && !pslverr;
	wire        grp = acc && pwrite && paddr >= 8'h40 && paddr <= 8'hbf && paddr[3:0] != 4'hc;
	wire        big = pwdata > (paddr[3] ? 32'h2710 : 32'h0bb8);
	wire        low = pwdata < (paddr[3] ? 32'h1 : 32'h5);
	// Forcing makes trip untimed, so the pulse length is only judged on clean pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tlen  <= 0;
			taint <= 1'b0;
			stg   <= 1'b0;
			fcode <= 2'h0;
			fage  <= 2'h0;
		end else begin
			tlen  <= trip_out ? tlen + 1 : 0;
			taint <= stage_forcing_en || (taint && trip_out);
			stg   <= cwr ? pwdata[0] : stg;
			fcode <= cwr ? pwdata[9:8] : fcode;
			fage  <= (!stage_forcing_en || cwr) ? 2'h0 : fage + 2'(fage != 2'h3);
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_trip_len: assert property (trip_out && !taint |-> tlen < TRIP_CYCLES)
		else $error("trip pulse too long");
	a_trip_clear: assert property ($fell(trip_out) && !taint |-> tlen == TRIP_CYCLES)
		else $error("trip pulse wrong length");
	a_block_excl: assert property (blocked_out && !stage_forcing_en |->
		!trip_out && !alarm_out && !start_out) else $error("blocked with trip");
	a_alarm_stage: assert property ($rose(alarm_out) && !stage_forcing_en |-> stg)
		else $error("alarm in trip-only stage");
	a_force_show: assert property (fage == 2'h3 |-> trip_out == (fcode == 2'h2) &&
		alarm_out == (fcode == 2'h3) && blocked_out == (fcode == 2'h1) && !start_out)
		else $error("override not shown");
	a_thr_range: assert property (grp && (big || low) |-> pslverr)
		else $error("bad setting accepted");
	a_sel_range: assert property (acc && pwrite && paddr == 8'h00 && pwdata[7:4] > 4'ha |-> pslverr)
		else $error("bad selector accepted");
	a_ro_refuse: assert property (acc && pwrite && paddr == 8'h04 |-> pslverr)
		else $error("status write accepted");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved");
endmodule : vj_top_chk
bind vj_top vj_top_chk #(.PASS_CYCLES(PASS_CYCLES), .TRIP_CYCLES(TRIP_CYCLES)) u_chk (.pclk,
	.presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
	.stage_forcing_en, .start_out, .trip_out, .alarm_out, .blocked_out);

/* File: verif/tb_top.sv */
// Self-checking bench of the angle jump detector
`timescale 1ns/100ps
module tb_top;
	localparam int P = 200;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic         block_in, stage_forcing_en, start_out, trip_out, alarm_out, blocked_out;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rv;
	logic [111:0] chan_ang, chan_mag;
	logic [6:0]   chan_avail;
	logic [2:0]   active_group;
	logic         s_trip, s_alarm, s_blk, s_start;
	int           miscompares, n_tests, seed, cyc, ang[7];
	vj_top #(.PASS_CYCLES(P), .TRIP_CYCLES(50)) uut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .chan_ang, .chan_mag,
		.chan_avail, .block_in, .stage_forcing_en, .active_group, .start_out, .trip_out,
		.alarm_out, .blocked_out);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Sticky flags sampled away from the active edge
	always @(negedge pclk) begin
		s_trip |= trip_out;
		s_alarm |= alarm_out;
		s_blk |= blocked_out;
		s_start |= start_out;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			summarize();
		end
	end
	task summarize();
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk(re, e);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rv, exp);
		chk(re, e);
	endtask : rd
	function automatic logic [6:0] grp(input int s);
		case (s)
			0, 1: return 7'h07;
			5, 6: return 7'h38;
			10: return 7'h40;
			default: return (s < 5) ? 7'h01 << (s - 2) : 7'h01 << (s - 4);
		endcase
	endfunction : grp
	function automatic int lowch(input logic [6:0] g);
		for (int k = 6; k >= 0; k--)
			if (g[k]) lowch = k;
	endfunction : lowch
	// One jump on the channels of m, then five passes to see every outcome
	task run(input int sel, input logic stg, input logic [6:0] m, input int d,
		input logic blk, input logic uv, input logic [6:0] av);
		logic [6:0] g;
		logic       pt, pa, b, ok;
		int         s0, dd, ms0, mg, sd;
		g = grp(sel);
		s0 = lowch(g);
		ok = (g & av) == g;
		pt = ok && ((sel == 0 || sel == 5) ? (m & g) == g : (m & g) != 0);
		pa = pt && stg && d >= 500;
		pt = pt && d >= 1000;
		b = blk || (uv && g[1]);
		dd = 0;
		wr(8'h00, 32'(sel * 16 + int'(stg)), 1'b0);
		@(posedge pclk);
		for (int k = 0; k < 7; k++) begin
			sd = (ang[k] > 18000) ? -d : d;
			if (m[k]) ang[k] += sd;
			if (m[k] && k == s0) dd = sd;
			mg = 9600 + {$random(seed)} % 2400;
			if (k == s0) ms0 = mg;
			chan_ang[16*k+:16] <= 16'(ang[k]);
			chan_mag[16*k+:16] <= 16'((uv && k == 1) ? 9000 : mg);
		end
		block_in <= blk;
		chan_avail <= av;
		{s_trip, s_alarm, s_blk, s_start} = 4'h0;
		repeat (2 * P) @(posedge pclk);
		if (ok) rd(8'h08, 32'(dd), 1'b0);
		repeat (3 * P) @(posedge pclk);
		chk(s_trip, pt && !b);
		chk(s_alarm, pa && !b);
		chk(s_blk, (pt || pa) && b);
		chk(s_start, (pt || pa) && !b);
		apb(1'b0, 8'h04, 32'h0);
		chk(rv[2], !ok);
		if (ok) rd(8'h14, 32'(ms0 * 100 / 9500), 1'b0);
	endtask : run
	initial begin
		seed = 6;
		{psel, penable, pwrite, paddr, pwdata, block_in, stage_forcing_en} = '0;
		{s_trip, s_alarm, s_blk, s_start} = 4'h0;
		chan_avail = 7'h7f;
		active_group = 3'h3;
		for (int k = 0; k < 7; k++) begin
			ang[k] = 15000 + {$random(seed)} % 6000;
			chan_ang[16*k+:16] = 16'(ang[k]);
			chan_mag[16*k+:16] = 16'h2580;
		end
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h10, 1'b0);
		for (int g = 0; g < 8; g++) begin
			rd(8'(64 + 16 * g), 32'd500, 1'b0);
			rd(8'(68 + 16 * g), 32'd500, 1'b0);
			rd(8'(72 + 16 * g), 32'd9500, 1'b0);
		end
		wr(8'h40, 32'd4, 1'b1);
		wr(8'h40, 32'd3001, 1'b1);
		wr(8'h40, 32'h10005, 1'b1);
		wr(8'h44, 32'd3000, 1'b0);
		wr(8'h48, 32'd0, 1'b1);
		wr(8'h48, 32'd10000, 1'b0);
		rd(8'h40, 32'd500, 1'b0);
		rd(8'h44, 32'd3000, 1'b0);
		wr(8'h00, 32'hb0, 1'b1);
		wr(8'h04, 32'h0, 1'b1);
		rd(8'h4c, 32'h0, 1'b1);
		wr(8'h70, 32'd1000, 1'b0);
		wr(8'h74, 32'd500, 1'b0);
		repeat (5 * P) @(posedge pclk);
		chk({s_trip, s_start}, 2'b00);
		for (int s = 0; s < 11; s++) begin
			run(s, 1'b1, 7'h01 << lowch(grp(s)), 1000, 1'b0, 1'b0, 7'h7f);
			run(s, 1'b1, grp(s), 1000, 1'b0, 1'b0, 7'h7f);
		end
		run(1, 1'b1, 7'h01, 999, 1'b0, 1'b0, 7'h7f);
		run(1, 1'b0, 7'h01, 999, 1'b0, 1'b0, 7'h7f);
		run(1, 1'b0, 7'h02, 1000, 1'b0, 1'b0, 7'h7f);
		run(1, 1'b1, 7'h04, 499, 1'b0, 1'b0, 7'h7f);
		run(1, 1'b1, 7'h01, 1000, 1'b1, 1'b0, 7'h7f);
		run(1, 1'b1, 7'h02, 1000, 1'b0, 1'b1, 7'h7f);
		run(1, 1'b1, 7'h01, 0, 1'b1, 1'b0, 7'h7f);
		run(2, 1'b1, 7'h01, 1000, 1'b0, 1'b0, 7'h7e);
		repeat (5) run(1, 1'b1, 7'h01 << ({$random(seed)} % 3), {$random(seed)} % 1600,
			1'b0, 1'b0, 7'h7f);
		stage_forcing_en <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, 32'(c * 256 + 17), 1'b0);
			repeat (4) @(posedge pclk);
			chk({blocked_out, trip_out, alarm_out, start_out}, (c == 0) ? 0 : 16 >> c);
		end
		wr(8'h00, 32'h11, 1'b0);
		stage_forcing_en <= 1'b0;
		wr(8'h00, 32'h211, 1'b0);
		repeat (4) @(posedge pclk);
		chk(trip_out, 1'b0);
		active_group <= 3'h5;
		rd(8'h00, 32'h211, 1'b0);
		summarize();
	end
endmodule : tb_top
